// File: fault_status_params.svh
// Constants for the fault status reporting block
`ifndef FAULT_STATUS_PARAMS_SVH
`define FAULT_STATUS_PARAMS_SVH

// ----------------------------------------------------------------
// Register selectors on the command port
// ----------------------------------------------------------------
`define SEL_CONDITION 3'h0
`define SEL_EVENT 3'h1
`define SEL_ENABLE_MASK 3'h2
`define SEL_FALLING_FILTER 3'h3
`define SEL_RISING_FILTER 3'h4
`define SEL_ERROR 3'h5

// ----------------------------------------------------------------
// Fault condition bit positions
// ----------------------------------------------------------------
`define BIT_INNER_ACDC 0
`define BIT_INNER_DCDC 1
`define BIT_OVERPOWER 2
`define BIT_OVERTEMP 3
`define BIT_OUTPUT_SHORT 4
`define BIT_FAN 5
`define BIT_OVERCURRENT 6
`define BIT_LINE_INPUT 7
`define BIT_OUTPUT_OVERVOLTAGE 8
`define FAULT_BITS 9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_ENABLE_MASK 16'h0000
`define RST_FALLING_FILTER 16'h0000
`define RST_RISING_FILTER 9'h1FF

`endif

// File: fault_status_pkg.sv
// Types shared by the fault status reporting block
`default_nettype none
package fault_status_pkg;

    typedef enum logic [2:0] {
        ERR_NONE = 3'b000,
        ERR_DATA_FORMAT = 3'b001,
        ERR_DATA_RANGE = 3'b010,
        ERR_TOO_MANY = 3'b011,
        ERR_EXECUTION = 3'b100
    } parser_error_t;

    typedef enum logic [0:0] {
        PANEL_LOCAL = 1'b0,
        PANEL_REMOTE = 1'b1
    } panel_state_t;

endpackage
`default_nettype wire

// File: sync2.sv
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= INIT;
            sync_out <= INIT;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule
`default_nettype wire

// File: fault_status_regs.sv
// Fault status registers, parser error report, panel lockout and rear TTL signals
`timescale 1ns/10ps
`default_nettype none
`include "fault_status_params.svh"
module fault_status_regs
    import fault_status_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fault sources from the power stages (asynchronous)
    input wire logic output_overvoltage_fault,
    input wire logic line_input_fault,
    input wire logic overcurrent_fault,
    input wire logic fan_fault,
    input wire logic output_short_fault,
    input wire logic overtemp_fault,
    input wire logic overpower_fault,
    input wire logic inner_dcdc_stage_fault,
    input wire logic inner_acdc_stage_fault,
    // Command port from the text parser
    input wire logic cmd_write,
    input wire logic cmd_read,
    input wire logic [2:0] cmd_sel,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_rvalid,
    // Parser error report
    input wire logic parser_error_valid,
    input wire parser_error_t parser_error_code,
    // Panel lockout commands
    input wire logic go_local_command,
    input wire logic go_remote_command,
    input wire logic cmd_from_serial,
    input wire logic [7:0] panel_keys,
    input wire logic [2:0] page_exit_key_index,
    output logic [7:0] panel_keys_accepted,
    output logic remote_state,
    // Status byte summary
    input wire logic summary_enable,
    output logic fault_summary_bit,
    // Output stage
    input wire logic output_request,
    input wire logic output_delivering,
    output logic output_enable,
    // Rear TTL pins
    input wire logic remote_inhibit_n,
    output logic output_on_indicator,
    output logic fault_out_n
);

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [`FAULT_BITS-1:0] fault_raw;
    logic [`FAULT_BITS-1:0] fault_sync;
    logic inhibit_n_sync;

    assign fault_raw[`BIT_OUTPUT_OVERVOLTAGE] = output_overvoltage_fault;
    assign fault_raw[`BIT_LINE_INPUT] = line_input_fault;
    assign fault_raw[`BIT_OVERCURRENT] = overcurrent_fault;
    assign fault_raw[`BIT_FAN] = fan_fault;
    assign fault_raw[`BIT_OUTPUT_SHORT] = output_short_fault;
    assign fault_raw[`BIT_OVERTEMP] = overtemp_fault;
    assign fault_raw[`BIT_OVERPOWER] = overpower_fault;
    assign fault_raw[`BIT_INNER_DCDC] = inner_dcdc_stage_fault;
    assign fault_raw[`BIT_INNER_ACDC] = inner_acdc_stage_fault;

    sync2 #(.WIDTH(`FAULT_BITS), .INIT('0)) fault_sync_u (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(fault_raw),
        .sync_out(fault_sync)
    );

    // Inhibit idles released so a reset never looks like an inhibit pulse
    sync2 #(.WIDTH(1), .INIT(1'b1)) inhibit_sync_u (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(remote_inhibit_n),
        .sync_out(inhibit_n_sync)
    );

    // ----------------------------------------------------------------
    // Condition, filters and event accumulation
    // ----------------------------------------------------------------
    logic [`FAULT_BITS-1:0] condition_r;
    logic [`FAULT_BITS-1:0] event_r;
    logic [`FAULT_BITS-1:0] event_nxt;
    logic [15:0] enable_mask_r;
    logic [15:0] falling_filter_r;
    logic [8:0] rising_filter_r;
    logic [`FAULT_BITS-1:0] rise_seen;
    logic [`FAULT_BITS-1:0] fall_seen;
    logic [`FAULT_BITS-1:0] passed_edges;
    logic [15:0] condition_word;
    logic [15:0] event_word;
    logic event_read;

    // Condition register follows the synchronised sources every cycle
    assign condition_word = {7'h00, condition_r};
    assign event_word = {7'h00, event_r};

    assign rise_seen = fault_sync & ~condition_r;
    assign fall_seen = ~fault_sync & condition_r;
    // Either filter alone or both together pass their edge; both zero pass nothing
    assign passed_edges = (rise_seen & rising_filter_r)
                        | (fall_seen & falling_filter_r[`FAULT_BITS-1:0]);

    assign event_read = cmd_read && (cmd_sel == `SEL_EVENT);
    // An edge landing in the reading cycle survives the clear
    assign event_nxt = (event_read ? '0 : event_r) | passed_edges;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            condition_r <= '0;
            event_r <= '0;
        end else begin
            condition_r <= fault_sync;
            event_r <= event_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Host writable registers
    // ----------------------------------------------------------------
    logic wr_enable_mask;
    logic wr_falling;
    logic wr_rising;

    assign wr_enable_mask = cmd_write && (cmd_sel == `SEL_ENABLE_MASK);
    assign wr_falling = cmd_write && (cmd_sel == `SEL_FALLING_FILTER);
    assign wr_rising = cmd_write && (cmd_sel == `SEL_RISING_FILTER);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_mask_r <= `RST_ENABLE_MASK;
            falling_filter_r <= `RST_FALLING_FILTER;
            rising_filter_r <= `RST_RISING_FILTER;
        end else begin
            if (wr_enable_mask) begin
                enable_mask_r <= cmd_wdata;
            end
            if (wr_falling) begin
                falling_filter_r <= cmd_wdata;
            end
            // Upper bits beyond 511 are dropped; the parser flags range errors
            if (wr_rising) begin
                rising_filter_r <= cmd_wdata[8:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Summary bit
    // ----------------------------------------------------------------
    logic masked_events;

    assign masked_events = |(event_word & enable_mask_r);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault_summary_bit <= 1'b0;
        end else begin
            fault_summary_bit <= summary_enable && masked_events;
        end
    end

    // ----------------------------------------------------------------
    // Parser error report
    // ----------------------------------------------------------------
    parser_error_t last_error_r;

    // Reading the error hands back the latest code and returns to no error unless a new code arrives in that cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            last_error_r <= ERR_NONE;
        end else if (parser_error_valid) begin
            last_error_r <= parser_error_code;
        end else if (cmd_read && (cmd_sel == `SEL_ERROR)) begin
            last_error_r <= ERR_NONE;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [15:0] read_mux;

    always_comb begin
        read_mux = 16'h0000;
        unique case (cmd_sel)
            `SEL_CONDITION: read_mux = condition_word;
            `SEL_EVENT: read_mux = event_word;
            `SEL_ENABLE_MASK: read_mux = enable_mask_r;
            `SEL_FALLING_FILTER: read_mux = falling_filter_r;
            `SEL_RISING_FILTER: read_mux = {7'h00, rising_filter_r};
            `SEL_ERROR: read_mux = {13'h0000, last_error_r};
            default: read_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_rdata <= 16'h0000;
            cmd_rvalid <= 1'b0;
        end else begin
            cmd_rvalid <= cmd_read;
            if (cmd_read) begin
                cmd_rdata <= read_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Front panel lockout
    // ----------------------------------------------------------------
    panel_state_t panel_r;
    logic local_taken;
    logic remote_taken;
    logic [7:0] page_exit_mask;

    // Commands arriving over any other path are ignored
    assign local_taken = go_local_command && cmd_from_serial;
    assign remote_taken = go_remote_command && cmd_from_serial;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            panel_r <= PANEL_LOCAL;
        end else if (local_taken) begin
            panel_r <= PANEL_LOCAL;
        end else if (remote_taken) begin
            panel_r <= PANEL_REMOTE;
        end
    end

    assign remote_state = (panel_r == PANEL_REMOTE);
    assign page_exit_mask = 8'h01 << page_exit_key_index;
    assign panel_keys_accepted = remote_state ? (panel_keys & page_exit_mask) : panel_keys;

    // ----------------------------------------------------------------
    // Output control and rear TTL pins
    // ----------------------------------------------------------------
    logic protection_active;

    assign protection_active = |condition_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            output_enable <= 1'b0;
            output_on_indicator <= 1'b0;
            fault_out_n <= 1'b1;
        end else begin
            // Inhibit drops the output three clocks after its pin, protection four clocks after a fault pin
            output_enable <= output_request && inhibit_n_sync && !protection_active;
            output_on_indicator <= output_delivering;
            fault_out_n <= !protection_active;
        end
    end

endmodule
`default_nettype wire

// File: fault_status_checker.sv
// Port assertions for the fault status block
`timescale 1ns/10ps
`default_nettype none
module fault_status_checker (
    // Ports watched on the block
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_read,
    input wire logic cmd_rvalid,
    input wire logic summary_enable,
    input wire logic fault_summary_bit,
    input wire logic output_request,
    input wire logic output_enable,
    input wire logic remote_inhibit_n,
    input wire logic go_local_command,
    input wire logic go_remote_command,
    input wire logic cmd_from_serial,
    input wire logic remote_state
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    read_answer_a: assert property (cmd_read |=> cmd_rvalid) else $error("read unanswered");
    answer_cause_a: assert property (cmd_rvalid |-> $past(cmd_read)) else $error("stray answer");
    summary_gate_a: assert property (!summary_enable |=> !fault_summary_bit) else $error("summary ungated");
    inhibit_stop_a: assert property (!remote_inhibit_n [*3] |=> !output_enable) else $error("inhibit ignored");
    request_gate_a: assert property (!output_request |=> !output_enable) else $error("output unrequested");
    remote_enter_a: assert property (go_remote_command && cmd_from_serial && !go_local_command
        |=> remote_state) else $error("remote not entered");
    local_enter_a: assert property (go_local_command && cmd_from_serial |=> !remote_state) else $error("no local");
    serial_only_a: assert property (!cmd_from_serial |=> $stable(remote_state)) else $error("panel moved");
endmodule
bind fault_status_regs fault_status_checker checker_i (.*);
`default_nettype wire

// File: host_model.sv
// Host model issuing register commands on the command port
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // Command port towards the block
    input wire logic clk,
    output logic cmd_write,
    output logic cmd_read,
    output logic [2:0] cmd_sel,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid
);
    logic timed_out;
    initial {cmd_write, cmd_read, cmd_sel, cmd_wdata, timed_out} = '0;
    // Released lines show the inverse so a stale value never passes for data
    task automatic wr(input logic [2:0] sel, input logic [15:0] d);
        @(negedge clk);
        {cmd_write, cmd_sel, cmd_wdata} = {1'b1, sel, d};
        @(negedge clk);
        {cmd_write, cmd_sel, cmd_wdata} = {1'b0, ~sel, ~d};
    endtask
    task automatic rd(input logic [2:0] sel, output logic [15:0] d);
        int i;
        @(negedge clk);
        {cmd_read, cmd_sel} = {1'b1, sel};
        @(negedge clk);
        {cmd_read, cmd_sel} = {1'b0, ~sel};
        for (i = 0; i < 4 && cmd_rvalid !== 1'b1; i++) @(negedge clk);
        timed_out = (cmd_rvalid !== 1'b1);
        d = cmd_rdata;
    endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the fault status block
`timescale 1ns/10ps
`default_nettype none
`include "fault_status_params.svh"
module testbench
    import fault_status_pkg::*;
;
    logic clk, rst_n, cmd_write, cmd_read, cmd_rvalid, parser_error_valid, go_local_command, go_remote_command;
    logic cmd_from_serial, remote_state, summary_enable, fault_summary_bit, output_request, output_delivering;
    logic output_enable, remote_inhibit_n, output_on_indicator, fault_out_n;
    logic [2:0] cmd_sel, page_exit_key_index;
    logic [7:0] panel_keys, panel_keys_accepted;
    logic [8:0] flt;
    logic [15:0] cmd_wdata, cmd_rdata;
    parser_error_t parser_error_code;
    int n_errors, samples_checked;
    fault_status_regs uut (.*, .output_overvoltage_fault(flt[8]), .line_input_fault(flt[7]),
        .overcurrent_fault(flt[6]), .fan_fault(flt[5]), .output_short_fault(flt[4]), .overtemp_fault(flt[3]),
        .overpower_fault(flt[2]), .inner_dcdc_stage_fault(flt[1]), .inner_acdc_stage_fault(flt[0]));
    host_model host (.*);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [2:0] sel, input logic [15:0] exp);
        logic [15:0] d;
        host.rd(sel, d);
        if (host.timed_out) stop_test();
        chk(d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic stop_test();
        n_errors += int'(host.timed_out);
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic t_regs();
        rdc(`SEL_RISING_FILTER, 16'h01FF);
        host.wr(`SEL_ENABLE_MASK, 16'hFFFF);
        host.wr(`SEL_FALLING_FILTER, 16'hFFFF);
        host.wr(`SEL_RISING_FILTER, 16'hFE00);
        host.wr(`SEL_CONDITION, 16'h00FF);
        host.wr(`SEL_EVENT, 16'h01FF);
        rdc(`SEL_ENABLE_MASK, 16'hFFFF);
        rdc(`SEL_FALLING_FILTER, 16'hFFFF);
        rdc(`SEL_RISING_FILTER, 16'h0000);
        rdc(`SEL_CONDITION, 16'h0000);
        rdc(`SEL_EVENT, 16'h0000);
        host.wr(`SEL_RISING_FILTER, 16'h01FF);
        $display("registers done");
    endtask
    task automatic t_faults();
        summary_enable = 1'b1;
        // Walking one: each step raises one bit and drops the one below
        for (int i = 0; i < `FAULT_BITS; i++) begin
            flt = 9'(1 << i);
            cyc(6);
            rdc(`SEL_CONDITION, 16'(1 << i));
            rdc(`SEL_EVENT, 16'((3 << i) >> 1));
        end
        host.wr(`SEL_ENABLE_MASK, 16'h0002);
        host.wr(`SEL_RISING_FILTER, 16'h0001);
        flt = 9'h003;
        cyc(6);
        chk(16'(fault_summary_bit), 16'h0000);
        rdc(`SEL_EVENT, 16'h0101);
        host.wr(`SEL_FALLING_FILTER, 16'h0000);
        flt = 9'h000;
        cyc(6);
        rdc(`SEL_EVENT, 16'h0000);
        host.wr(`SEL_ENABLE_MASK, 16'h0001);
        flt = 9'h001;
        cyc(6);
        chk(16'(fault_summary_bit), 16'h0001);
        rdc(`SEL_EVENT, 16'h0001);
        flt = 9'h000;
        $display("faults done");
    endtask
    task automatic t_err();
        for (int i = 0; i < 5; i++) begin
            parser_error_code = parser_error_t'(i);
            parser_error_valid = 1'b1;
            cyc(1);
            parser_error_valid = 1'b0;
            rdc(`SEL_ERROR, 16'(i));
        end
        rdc(`SEL_ERROR, 16'h0000);
        $display("errors done");
    endtask
    task automatic t_panel();
        {panel_keys, page_exit_key_index, go_remote_command} = {8'hFF, 3'h5, 1'b1};
        cyc(1);
        chk(16'(remote_state), 16'h0000);
        cmd_from_serial = 1'b1;
        cyc(1);
        go_remote_command = 1'b0;
        chk(16'({remote_state, panel_keys_accepted}), 16'h0120);
        // Go-local from any path but the serial link must leave the panel locked
        {go_local_command, cmd_from_serial} = 2'b10;
        cyc(1);
        chk(16'(remote_state), 16'h0001);
        cmd_from_serial = 1'b1;
        cyc(1);
        go_local_command = 1'b0;
        chk(16'({remote_state, panel_keys_accepted}), 16'h00FF);
        $display("panel done");
    endtask
    task automatic t_out();
        {output_request, output_delivering} = 2'b11;
        cyc(5);
        chk(16'({output_enable, output_on_indicator, fault_out_n}), 16'h0007);
        {remote_inhibit_n, output_delivering} = 2'b00;
        cyc(3);
        chk(16'({output_enable, output_on_indicator, fault_out_n}), 16'h0001);
        {remote_inhibit_n, flt} = {1'b1, 9'h010};
        cyc(5);
        chk(16'({output_enable, output_on_indicator, fault_out_n}), 16'h0000);
        flt = 9'h000;
        cyc(6);
        chk(16'({output_enable, output_on_indicator, fault_out_n}), 16'h0005);
        $display("output done");
    endtask
    initial begin
        {rst_n, flt, parser_error_valid, go_local_command, go_remote_command, cmd_from_serial} = '0;
        {panel_keys, page_exit_key_index, summary_enable, output_request, output_delivering} = '0;
        remote_inhibit_n = 1'b1;
        parser_error_code = ERR_NONE;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_regs();
        t_faults();
        t_err();
        t_panel();
        t_out();
        stop_test();
    end
endmodule
`default_nettype wire
